// ==== rtl/tsi_host_i2c.sv ====
// two-wire slave, register file and channel readout of the touch controller
// assumes open-drain pins resolved outside; conversion side on the same clock
`timescale 1ns/1ps
`include "tsi_cfg.svh"
module tsi_host_i2c
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  output logic interrupt_request_n,
  input wire logic adc_valid,
  input wire logic [2:0] adc_channel_tag,
  input wire tsi_pkg::tsi_sample_t adc_data,
  input wire logic seq_start,
  input wire logic seq_done,
  input wire logic pen_detect,
  input wire logic pen_present,
  input wire logic sampling_busy,
  output tsi_pkg::tsi_byte_t control_word_0,
  output tsi_pkg::tsi_byte_t control_word_1,
  output tsi_pkg::tsi_byte_t control_word_2,
  output tsi_pkg::tsi_byte_t control_word_3,
  output tsi_pkg::tsi_byte_t channel_enable_mask,
  output logic cmd_valid,
  output logic [6:0] cmd_code
);
  import tsi_pkg::*;
  tsi_state_t st_r;
  logic [2:0] s1_r, s2_r;
  logic [1:0] prev_r;
  logic scl_s, sda_s, a0_s, rise, fall, start_evt, stop_evt;
  logic [3:0] bit_cnt_r;
  tsi_byte_t shift_r, tx_sr_r, tx_byte, stat_r;
  logic rw_r, first_r, mack_r, hold_r, srst_r, pen_event_flag_r, irq_r;
  logic wr_mode_r, rd_reg_mode_r;
  logic [4:0] register_index_r;
  logic rx_byte, cmd_byte, wr_data_evt, ld_tx, addr_hit, addr_rd, ld_stat, channel_tag_nack;
  logic [2:0] ch_ptr_r, cur_ch_r, ch_sel;
  logic lo_r, word_ok;
  logic [4:0] ch_valid_r;
  tsi_sample_t ch_data_r [0:`TSI_NCHAN-1];
  logic [15:0] word;
  logic f_valid;
  logic [2:0] f_channel_tag;
  tsi_sample_t f_data;

  // lowest enabled channel at or above a position; five means none left
  function automatic logic [2:0] first_en(input logic [4:0] m, input logic [2:0] from);
    logic [2:0] res;
    res = 3'h5;
    for (int i = `TSI_NCHAN-1; i >= 0; i--)
      if (m[i] && 3'(i) >= from)
        res = 3'(i);
    return res;
  endfunction

  function automatic tsi_byte_t reg_rd(input logic [4:0] idx);
    case (idx)
      `TSI_RA_CTRL0: reg_rd = control_word_0;
      `TSI_RA_CTRL1: reg_rd = control_word_1;
      `TSI_RA_CTRL2: reg_rd = control_word_2;
      `TSI_RA_CTRL3: reg_rd = control_word_3;
      `TSI_RA_MASK: reg_rd = channel_enable_mask;
      `TSI_RA_STAT: reg_rd = stat_r;
      default: reg_rd = 8'h00;
    endcase
  endfunction

  tsi_filter tsi_filter_inst
  (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(adc_valid),
    .in_channel_tag(adc_channel_tag),
    .in_data(adc_data),
    .filt_sel(control_word_1[1:0]),
    .out_valid(f_valid),
    .out_channel_tag(f_channel_tag),
    .out_data(f_data)
  );

  // pins pass two flops; bit 0 scl, bit 1 sda, bit 2 address select
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      s1_r <= 3'h3;
      s2_r <= 3'h3;
      prev_r <= 2'h3;
    end
    else
    begin
      s1_r <= {address_select_pin, sda_in, scl_in};
      s2_r <= s1_r;
      prev_r <= s2_r[1:0];
    end

  // bus events from the synchronised levels
  assign scl_s = s2_r[0];
  assign sda_s = s2_r[1];
  assign a0_s = s2_r[2];
  assign rise = scl_s && !prev_r[0];
  assign fall = !scl_s && prev_r[0];
  assign start_evt = scl_s && prev_r[0] && !sda_s && prev_r[1];
  assign stop_evt = scl_s && prev_r[0] && sda_s && !prev_r[1];
  assign addr_hit = shift_r[7:1] == {`TSI_ADDR_HI, a0_s};
  assign addr_rd = fall && st_r == TSI_ADDR && bit_cnt_r == 4'h8 && addr_hit && shift_r[0];
  assign rx_byte = fall && st_r == TSI_RX && bit_cnt_r == 4'h8;
  assign cmd_byte = rx_byte && first_r;
  assign wr_data_evt = rx_byte && !first_r && wr_mode_r;
  assign ld_tx = fall && ((st_r == TSI_AACK && rw_r) || (st_r == TSI_TACK && mack_r));
  assign ld_stat = ld_tx && rd_reg_mode_r && register_index_r == `TSI_RA_STAT;
  assign channel_tag_nack = fall && st_r == TSI_TACK && !mack_r && !rd_reg_mode_r;
  assign stat_r = {pen_event_flag_r, sampling_busy, 6'h00};

  always_comb
  begin
    ch_sel = lo_r ? cur_ch_r : first_en(channel_enable_mask[4:0],
      (st_r == TSI_AACK) ? 3'h0 : ch_ptr_r);
    word_ok = ch_sel < 3'(`TSI_NCHAN) && ch_valid_r[ch_sel];
    word = word_ok ? {1'b0, ch_sel, ch_data_r[ch_sel]} : `TSI_INVALID;
    if (rd_reg_mode_r)
      tx_byte = reg_rd(register_index_r);
    else if (ch_sel >= 3'(`TSI_NCHAN))
      tx_byte = `TSI_FILL;
    else
      tx_byte = lo_r ? word[7:0] : word[15:8];
  end

  // byte framing: addresses, acks and shifting on scl edges
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      st_r <= TSI_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_sr_r <= 8'h00;
      sda_oe <= 1'b0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (stop_evt)
    begin
      st_r <= TSI_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_evt)
    begin
      st_r <= TSI_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end
    else
    begin
      if (rise)
      begin
        shift_r <= {shift_r[6:0], sda_s};
        if (st_r == TSI_ADDR || st_r == TSI_RX)
          bit_cnt_r <= bit_cnt_r + 4'h1;
        if (st_r == TSI_TACK)
          mack_r <= !sda_s;
      end
      if (fall)
        case (st_r)
          TSI_ADDR:
            if (bit_cnt_r == 4'h8)
            begin
              st_r <= addr_hit ? TSI_AACK : TSI_IDLE;
              sda_oe <= addr_hit;
              rw_r <= shift_r[0];
              bit_cnt_r <= 4'h0;
            end
          TSI_AACK:
            if (rw_r)
            begin
              st_r <= TSI_TX;
              tx_sr_r <= tx_byte;
              sda_oe <= !tx_byte[7];
              bit_cnt_r <= 4'h1;
            end
            else
            begin
              st_r <= TSI_RX;
              sda_oe <= 1'b0;
              first_r <= 1'b1;
            end
          TSI_RX:
            if (bit_cnt_r == 4'h8)
            begin
              st_r <= TSI_RACK;
              sda_oe <= 1'b1;
              bit_cnt_r <= 4'h0;
            end
          TSI_RACK:
          begin
            st_r <= TSI_RX;
            sda_oe <= 1'b0;
            first_r <= 1'b0;
          end
          TSI_TX:
            if (bit_cnt_r == 4'h8)
            begin
              st_r <= TSI_TACK;
              sda_oe <= 1'b0;
            end
            else
            begin
              tx_sr_r <= {tx_sr_r[6:0], 1'b0};
              sda_oe <= !tx_sr_r[6];
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          TSI_TACK:
            if (mack_r)
            begin
              // next byte while the host acknowledges
              st_r <= TSI_TX;
              tx_sr_r <= tx_byte;
              sda_oe <= !tx_byte[7];
              bit_cnt_r <= 4'h1;
            end
            else
              st_r <= TSI_IDLE;
          default: st_r <= TSI_IDLE;
        endcase
    end

  // index, transfer mode and register writes
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      register_index_r <= 5'h00;
      wr_mode_r <= 1'b0;
      rd_reg_mode_r <= 1'b0;
      srst_r <= 1'b0;
      control_word_0 <= `TSI_CTRL_RST;
      control_word_1 <= `TSI_CTRL1_RST;
      control_word_2 <= `TSI_CTRL_RST;
      control_word_3 <= `TSI_CTRL_RST;
      channel_enable_mask <= `TSI_MASK_RST;
    end
    else
    begin
      srst_r <= wr_data_evt && register_index_r == `TSI_RA_SRST;
      if (stop_evt)
        rd_reg_mode_r <= 1'b0;
      if (start_evt)
        wr_mode_r <= 1'b0;
      if (cmd_byte && shift_r[7:5] == `TSI_CMD_WR)
        wr_mode_r <= 1'b1;
      if (cmd_byte && shift_r[7:5] == `TSI_CMD_RD)
        rd_reg_mode_r <= 1'b1;
      if (cmd_byte && !shift_r[7])
        register_index_r <= shift_r[4:0];
      else if (wr_data_evt || (ld_tx && rd_reg_mode_r))
        register_index_r <= register_index_r + 5'h01;
      if (srst_r)
      begin
        control_word_0 <= `TSI_CTRL_RST;
        control_word_1 <= `TSI_CTRL1_RST;
        control_word_2 <= `TSI_CTRL_RST;
        control_word_3 <= `TSI_CTRL_RST;
        channel_enable_mask <= `TSI_MASK_RST;
      end
      else if (wr_data_evt)
        case (register_index_r)
          `TSI_RA_CTRL0: control_word_0 <= shift_r;
          `TSI_RA_CTRL1: control_word_1 <= shift_r;
          `TSI_RA_CTRL2: control_word_2 <= shift_r;
          `TSI_RA_CTRL3: control_word_3 <= shift_r;
          `TSI_RA_MASK: channel_enable_mask <= shift_r;
          default: ;
        endcase
    end

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= 7'h00;
    end
    else
    begin
      cmd_valid <= cmd_byte && shift_r[7];
      if (cmd_byte && shift_r[7])
        cmd_code <= shift_r[6:0];
    end

  // clock stretch while sampling is busy
  // register reads are exempt so a status poll never stalls the bus
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      hold_r <= 1'b0;
    else if (!sampling_busy)
      hold_r <= 1'b0;
    else if ((addr_rd || rx_byte) && !rd_reg_mode_r &&
      !(cmd_byte && shift_r[7:5] == `TSI_CMD_RD))
      hold_r <= 1'b1;

  // open-drain pins only ever pull low
  assign scl_oe = hold_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      ch_ptr_r <= 3'h0;
      cur_ch_r <= 3'h0;
      lo_r <= 1'b0;
    end
    else if (ld_tx && !rd_reg_mode_r)
    begin
      lo_r <= !lo_r && ch_sel < 3'(`TSI_NCHAN);
      cur_ch_r <= ch_sel;
      if (lo_r)
        ch_ptr_r <= cur_ch_r + 3'h1;
    end
    else if (addr_rd)
      lo_r <= 1'b0;

  // results of the latest sequence only
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      ch_valid_r <= 5'h00;
      for (int c = 0; c < `TSI_NCHAN; c++)
        ch_data_r[c] <= 12'h000;
    end
    else
    begin
      if (seq_start || srst_r)
        ch_valid_r <= 5'h00;
      if (f_valid && f_channel_tag < 3'(`TSI_NCHAN))
      begin
        ch_data_r[f_channel_tag] <= f_data;
        ch_valid_r[f_channel_tag] <= pen_present;
      end
    end

  // pen flag and interrupt; a new event beats the clear
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      pen_event_flag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (pen_detect)
        pen_event_flag_r <= 1'b1;
      else if (ld_stat || srst_r)
        pen_event_flag_r <= 1'b0;
      if (pen_detect || seq_done)
        irq_r <= 1'b1;
      else if (ld_stat || channel_tag_nack || srst_r)
        irq_r <= 1'b0;
    end
  assign interrupt_request_n = !irq_r;

  property p_ack;
    @(posedge mclk) disable iff (!resetn)
    st_r == TSI_AACK || st_r == TSI_RACK |-> sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not driven");

  property p_idx;
    @(posedge mclk) disable iff (!resetn)
    wr_data_evt |=> register_index_r == $past(register_index_r) + 5'h01;
  endproperty
  a_idx: assert property (p_idx) else $error("index did not advance");

  property p_stop;
    @(posedge mclk) disable iff (!resetn)
    stop_evt |=> !rd_reg_mode_r;
  endproperty
  a_stop: assert property (p_stop) else $error("register read outlived stop");

  property p_nostretch;
    @(posedge mclk) disable iff (!resetn)
    rd_reg_mode_r && !$past(hold_r) |-> !scl_oe;
  endproperty
  a_nostretch: assert property (p_nostretch) else $error("stretch in register read");

  property p_invalid;
    @(posedge mclk) disable iff (!resetn)
    ld_tx && !rd_reg_mode_r && !word_ok |=> tx_sr_r == `TSI_FILL;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid word not all ones");

  property p_seq;
    @(posedge mclk) disable iff (!resetn)
    seq_start && !f_valid |=> ch_valid_r == 5'h00;
  endproperty
  a_seq: assert property (p_seq) else $error("stale channel data kept");

  property p_pen;
    @(posedge mclk) disable iff (!resetn)
    pen_detect |=> pen_event_flag_r && !interrupt_request_n;
  endproperty
  a_pen: assert property (p_pen) else $error("pen event lost");

  property p_statclr;
    @(posedge mclk) disable iff (!resetn)
    ld_stat && !pen_detect |=> !pen_event_flag_r;
  endproperty
  a_statclr: assert property (p_statclr) else $error("status read kept pen flag");
endmodule

// ==== common/tsi_cfg.svh ====
// constants for the touch controller host link: offsets, fields, resets, filter figures
// assumes one clock domain at 50 MHz and a two-wire bus resolved outside
// Overview of operation
// - filter zero passes samples; one averages three
// - filter two averages latest five samples
// - filter three: middle three of seven averaged
// - every average scaled by 4079/4095
// - seven-bit slave only, standard and fast rates
// - address low bit follows address select pin
// - acknowledge written bytes, index steps per byte
// - stretch after command bits while sampling busy
// - 010+index, repeated start, read until NACK
// - register reads end at stop; then channels
// - register reads never stretch the clock
// - channel read streams; final NACK releases interrupt
// - at most ten bytes, two per channel
// - channel order X, Y, Z1, Z2, auxiliary
// - channel read may stretch after address byte
// - word is three-bit tag plus twelve-bit value
// - unconverted or penless channels read all ones
// - readable data is the latest sequence only
// - five-bit index over seven documented registers
// - pen sets flag; status read clears it
// - low hardware reset clears control logic
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH
`define TSI_ADDR_HI 6'h24
`define TSI_RA_CTRL0 5'h00
`define TSI_RA_CTRL1 5'h01
`define TSI_RA_CTRL2 5'h02
`define TSI_RA_CTRL3 5'h03
`define TSI_RA_MASK 5'h04
`define TSI_RA_STAT 5'h05
`define TSI_RA_SRST 5'h1f
`define TSI_CTRL_RST 8'h00
`define TSI_CTRL1_RST 8'h20
`define TSI_MASK_RST 8'h00
`define TSI_STAT_PEN 7
`define TSI_STAT_BUSY 6
`define TSI_CMD_WR 3'h0
`define TSI_CMD_RD 3'h2
`define TSI_NCHAN 5
`define TSI_NWIN 7
`define TSI_AVG_A 28'h3
`define TSI_AVG_B 28'h5
`define TSI_MED_LO 3'h2
`define TSI_MED_HI 3'h4
`define TSI_K_NUM 28'hfef
`define TSI_K_DEN 28'hfff
`define TSI_INVALID 16'hffff
`define TSI_FILL 8'hff
`endif

// ==== common/tsi_pkg.sv ====
// types shared by the touch controller host link
// assumes the constants header is compiled alongside
package tsi_pkg;
  typedef logic [7:0] tsi_byte_t;
  typedef logic [11:0] tsi_sample_t;
  // gray codes along address, ack, receive, ack, transmit, ack
  typedef enum logic [2:0] {
    TSI_IDLE = 3'h0,
    TSI_ADDR = 3'h1,
    TSI_AACK = 3'h3,
    TSI_RX = 3'h2,
    TSI_RACK = 3'h6,
    TSI_TX = 3'h7,
    TSI_TACK = 3'h5
  } tsi_state_t;
endpackage

// ==== rtl/tsi_filter.sv ====
// per-channel averaging and median filter on raw conversion samples
// assumes samples arrive on mclk with a channel number below five
`timescale 1ns/1ps
`include "tsi_cfg.svh"
module tsi_filter
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [2:0] in_channel_tag,
  input wire tsi_pkg::tsi_sample_t in_data,
  input wire logic [1:0] filt_sel,
  output logic out_valid,
  output logic [2:0] out_channel_tag,
  output tsi_pkg::tsi_sample_t out_data
);
  import tsi_pkg::*;
  tsi_sample_t hist_r [0:`TSI_NCHAN-1][0:`TSI_NWIN-2];
  tsi_sample_t win [0:`TSI_NWIN-1];
  logic [27:0] mid_part [0:`TSI_NWIN-1];
  logic [27:0] sum3, sum5, summid, num, den, prod, den_k, quo;
  logic [2:0] ch;
  tsi_sample_t res, k_exp;

  // window: newest sample and six older ones of the same channel
  always_comb
  begin
    ch = (in_channel_tag < 3'(`TSI_NCHAN)) ? in_channel_tag : 3'h0;
    win[0] = in_data;
    for (int k = 1; k < `TSI_NWIN; k++)
      win[k] = hist_r[ch][k-1];
  end

  // rank sort
  // rank by counting smaller entries; ties broken by position
  generate
    for (genvar i = 0; i < `TSI_NWIN; i++)
    begin : g_rank
      logic [2:0] r;
      always_comb
      begin
        r = 3'h0;
        for (int j = 0; j < `TSI_NWIN; j++)
          if (j != i && (win[j] < win[i] || (win[j] == win[i] && j < i)))
            r = r + 3'h1;
      end
      assign mid_part[i] = (r >= `TSI_MED_LO && r <= `TSI_MED_HI) ? 28'(win[i]) : 28'h0;
    end
  endgenerate

  always_comb
  begin
    sum3 = 28'(win[0]) + 28'(win[1]) + 28'(win[2]);
    sum5 = sum3 + 28'(win[3]) + 28'(win[4]);
    summid = 28'h0;
    for (int k = 0; k < `TSI_NWIN; k++)
      summid = summid + mid_part[k];
  end

  // scaled mean
  // constant divide kept combinational; the sample rate leaves a full cycle for it
  always_comb
  begin
    case (filt_sel)
      2'h1:
      begin
        num = sum3;
        den = `TSI_AVG_A;
      end
      2'h2:
      begin
        num = sum5;
        den = `TSI_AVG_B;
      end
      2'h3:
      begin
        num = summid;
        den = `TSI_AVG_A;
      end
      default:
      begin
        num = 28'(in_data);
        den = 28'h1;
      end
    endcase
    prod = num * `TSI_K_NUM;
    den_k = den * `TSI_K_DEN;
    quo = prod / den_k;
    res = (filt_sel == 2'h0) ? in_data : quo[11:0];
    quo = (28'(in_data) * `TSI_K_NUM) / `TSI_K_DEN;
    k_exp = quo[11:0];
  end

  // history shift, one lane per channel
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      for (int c = 0; c < `TSI_NCHAN; c++)
        for (int k = 0; k < `TSI_NWIN-1; k++)
          hist_r[c][k] <= 12'h000;
    end
    else if (in_valid)
    begin
      hist_r[ch][0] <= in_data;
      for (int k = 1; k < `TSI_NWIN-1; k++)
        hist_r[ch][k] <= hist_r[ch][k-1];
    end

  // registered result
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_channel_tag <= 3'h0;
      out_data <= 12'h000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
      begin
        out_channel_tag <= ch;
        out_data <= res;
      end
    end

  property p_pass;
    @(posedge mclk) disable iff (!resetn)
    in_valid && filt_sel == 2'h0 |=> out_valid && out_data == $past(in_data);
  endproperty
  a_pass: assert property (p_pass) else $error("unfiltered sample altered");

  property p_scale;
    @(posedge mclk) disable iff (!resetn)
    in_valid && filt_sel == 2'h1 && win[1] == in_data && win[2] == in_data
      |=> out_data == $past(k_exp);
  endproperty
  a_scale: assert property (p_scale) else $error("mean not scaled by filter constant");
endmodule

// ==== bench/tsi_host_model.sv ====
// host processor model: two-wire bus master at a 160 ns bit clock
// assumes pull-ups on both lines, the wire levels resolved in the bench
`timescale 1ns/1ps
module tsi_host_model
(
  input wire logic mclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int unsigned waited;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release the clock; a stretching slave holds it low, so wait, bounded
  task automatic rise();
    @(posedge mclk) scl_low <= 1'b0;
    waited = 0;
    while (scl !== 1'b1 && waited < 4000)
    begin
      @(posedge mclk);
      waited++;
    end
    // four cycles high, four low: a 160 ns bit clock
    repeat (3) @(posedge mclk);
  endtask
  // data moves one cycle after the clock fall, sampled at end of high
  task automatic xbit(input logic b, output logic r);
    @(posedge mclk) sda_low <= !b;
    repeat (2) @(posedge mclk);
    rise();
    r = sda;
    scl_low <= 1'b1;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
    output logic r9);
    for (int i = 7; i >= 0; i--)
      xbit(tx[i], rx[i]);
    xbit(nine, r9);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    @(posedge mclk) sda_low <= 1'b0;
    repeat (3) @(posedge mclk);
    rise();
    sda_low <= 1'b1;
    repeat (4) @(posedge mclk);
    scl_low <= 1'b1;
  endtask
  // stop: data rises while the clock is high, then the bus rests
  task automatic stop_cond();
    @(posedge mclk) sda_low <= 1'b1;
    repeat (3) @(posedge mclk);
    rise();
    sda_low <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// ==== bench/tb.sv ====
// self-checking bench: host model on the bus, bench drives the conversion side
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`include "tsi_cfg.svh"
module tb;
  import tsi_pkg::*;
  logic mclk, resetn, pin, adc_valid, seq_start, seq_done, pen_detect, pen_present, busy;
  logic scl, sda, scl_low, sda_low, scl_oe, sda_oe, irq_n, cmd_valid, stretched, cmd_seen, r9;
  logic [2:0] adc_channel_tag;
  logic [6:0] cmd_code;
  tsi_sample_t adc_data;
  tsi_byte_t ctrl0, ctrl1, ctrl2, ctrl3, mask, rx;
  int miscompares, num_checks;
  // X word per filter after four zeros and three fff samples, K = fef/fff:
  // plain fff, fff*K, 3*fff*K/5, fff*K/3 (middle three are 0, 0, fff)
  logic [15:0] filt_exp [0:3] = '{16'h0fff, 16'h0fef, 16'h098f, 16'h054f};
  // open-drain wires with pull-ups
  assign scl = !(scl_low || scl_oe);
  assign sda = !(sda_low || sda_oe);
  tsi_host_i2c tsi_host_i2c_inst
  (
    .mclk(mclk),
    .resetn(resetn),
    .scl_in(scl),
    .scl_out(),
    .scl_oe(scl_oe),
    .sda_in(sda),
    .sda_out(),
    .sda_oe(sda_oe),
    .address_select_pin(pin),
    .interrupt_request_n(irq_n),
    .adc_valid(adc_valid),
    .adc_channel_tag(adc_channel_tag),
    .adc_data(adc_data),
    .seq_start(seq_start),
    .seq_done(seq_done),
    .pen_detect(pen_detect),
    .pen_present(pen_present),
    .sampling_busy(busy),
    .control_word_0(ctrl0),
    .control_word_1(ctrl1),
    .control_word_2(ctrl2),
    .control_word_3(ctrl3),
    .channel_enable_mask(mask),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code)
  );
  tsi_host_model tsi_host_model_inst
  (
    .mclk(mclk),
    .scl(scl),
    .sda(sda),
    .scl_low(scl_low),
    .sda_low(sda_low)
  );
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // sticky flags, since stretch and command pulses are brief
  always @(posedge mclk)
  begin
    if (scl_oe === 1'b1)
      stretched <= 1'b1;
    if (cmd_valid === 1'b1)
      cmd_seen <= 1'b1;
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask
  task automatic send(input tsi_byte_t b, input logic ack);
    tsi_host_model_inst.xbyte(b, 1'b1, rx, r9);
    check("slave ack", {15'h0, !ack}, {15'h0, r9});
  endtask
  task automatic recv(input tsi_byte_t exp, input logic last);
    tsi_host_model_inst.xbyte(8'hff, last, rx, r9);
    check("read byte", {8'h00, exp}, {8'h00, rx});
  endtask
  function automatic tsi_byte_t addr(input logic rd);
    return {`TSI_ADDR_HI, 1'b0, rd};
  endfunction
  task automatic wr(input logic [4:0] idx, input tsi_byte_t d[$]);
    tsi_host_model_inst.start_cond();
    send(addr(1'b0), 1'b1);
    send({3'h0, idx}, 1'b1);
    foreach (d[i])
      send(d[i], 1'b1);
    tsi_host_model_inst.stop_cond();
  endtask
  task automatic rd(input logic [4:0] idx, input tsi_byte_t d[$]);
    tsi_host_model_inst.start_cond();
    send(addr(1'b0), 1'b1);
    send({3'h2, idx}, 1'b1);
    tsi_host_model_inst.start_cond();
    send(addr(1'b1), 1'b1);
    foreach (d[i])
      recv(d[i], i == d.size() - 1);
    tsi_host_model_inst.stop_cond();
  endtask
  // channel read
  // no conversion runs meanwhile, so the stop always comes first
  task automatic crd(input tsi_byte_t d[$]);
    tsi_host_model_inst.start_cond();
    send(addr(1'b1), 1'b1);
    foreach (d[i])
      recv(d[i], i == d.size() - 1);
    tsi_host_model_inst.stop_cond();
  endtask
  task automatic adc(input logic [2:0] ch, input tsi_sample_t v, input logic pen);
    @(posedge mclk);
    {adc_valid, adc_channel_tag, adc_data, pen_present} <= {1'b1, ch, v, pen};
    @(posedge mclk);
    adc_valid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // one-cycle strobe: 0 sequence start, 1 sequence done, 2 pen event
  task automatic strobe(input int which);
    @(posedge mclk);
    {seq_start, seq_done, pen_detect} <= 3'h4 >> which;
    @(posedge mclk);
    {seq_start, seq_done, pen_detect} <= 3'h0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // the run needs some 9k cycles; cut a hang well after that
  initial
  begin
    repeat (50000) @(posedge mclk);
    miscompares++;
    test_done();
  end
  initial
  begin
    {resetn, pin, adc_valid, seq_start, seq_done, pen_detect, busy, stretched, cmd_seen} = 9'h0;
    {adc_channel_tag, adc_data, pen_present, miscompares, num_checks} = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(5'h00, {8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00});
    // burst write whose sixth byte lands on read-only status
    wr(5'h00, {8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h1f, 8'h77});
    check("control_word_2", 16'h00c3, {8'h00, ctrl2});
    check("control_word_0_1", 16'ha1b2, {ctrl0, ctrl1});
    check("control_word_3_mask", 16'hd41f, {ctrl3, mask});
    rd(5'h00, {8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h1f, 8'h00});
    wr(5'h1f, {8'h5a});
    check("control_word_1", 16'h0020, {8'h00, ctrl1});
    rd(5'h00, {8'h00, 8'h20, 8'h00, 8'h00, 8'h00});
    // other address unanswered until the select pin moves the low bit
    tsi_host_model_inst.start_cond();
    send(8'h92, 1'b0);
    tsi_host_model_inst.stop_cond();
    @(posedge mclk) pin <= 1'b1;
    tsi_host_model_inst.start_cond();
    send(8'h92, 1'b1);
    tsi_host_model_inst.stop_cond();
    @(posedge mclk) pin <= 1'b0;
    // host command
    // command while sampling is busy must stretch
    @(posedge mclk) {busy, stretched} <= 2'b10;
    fork
      begin
        tsi_host_model_inst.start_cond();
        send(addr(1'b0), 1'b1);
        send(8'haa, 1'b1);
        tsi_host_model_inst.stop_cond();
      end
      begin
        repeat (400) @(posedge mclk);
        busy <= 1'b0;
      end
    join
    check("stretch", 16'h1, {15'h0, stretched});
    check("cmd_code", 16'h2a, {9'h0, cmd_code});
    check("cmd_valid", 16'h1, {15'h0, cmd_seen});
    @(posedge mclk) {busy, stretched} <= 2'b10;
    rd(5'h05, {8'h40});
    check("no stretch", 16'h0, {15'h0, stretched});
    @(posedge mclk) busy <= 1'b0;
    strobe(2);
    check("interrupt_request_n", 16'h0, {15'h0, irq_n});
    rd(5'h05, {8'h80});
    check("interrupt_request_n", 16'h1, {15'h0, irq_n});
    rd(5'h05, {8'h00});
    // all channels enabled, X and Y converted, Z1 without pen
    wr(5'h04, {8'h1f});
    strobe(0);
    adc(3'h0, 12'h123, 1'b1);
    adc(3'h1, 12'h456, 1'b1);
    adc(3'h2, 12'h0aa, 1'b0);
    strobe(1);
    check("interrupt_request_n", 16'h0, {15'h0, irq_n});
    crd({8'h01, 8'h23, 8'h14, 8'h56, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    check("interrupt_request_n", 16'h1, {15'h0, irq_n});
    strobe(0);
    adc(3'h1, 12'h789, 1'b1);
    strobe(1);
    // channel read while sampling is busy must stretch after the address
    @(posedge mclk) {busy, stretched} <= 2'b10;
    fork
      crd({8'hff, 8'hff, 8'h17, 8'h89});
      begin
        repeat (200) @(posedge mclk);
        busy <= 1'b0;
      end
    join
    check("stretch", 16'h1, {15'h0, stretched});
    // each filter: four zeros then three full-scale samples on X
    wr(5'h04, {8'h01});
    for (int f = 0; f < 4; f++)
    begin
      wr(5'h01, {8'h20 + 8'(f)});
      strobe(0);
      for (int k = 0; k < 7; k++)
        adc(3'h0, (k < 4) ? 12'h000 : 12'hfff, 1'b1);
      strobe(1);
      crd({filt_exp[f][15:8], filt_exp[f][7:0]});
    end
    test_done();
  end
endmodule
